// >>> src/smac_pkg.sv
package smac_pkg;
   // register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_FIRST = 8'h04;
   localparam logic [7:0] OFS_SECOND = 8'h08;
   localparam logic [7:0] OFS_ADDEND = 8'h0c;
   localparam logic [7:0] OFS_PAIR_LO = 8'h10;
   localparam logic [7:0] OFS_PAIR_HI = 8'h14;
   localparam logic [7:0] OFS_RESULT = 8'h18;
   localparam logic [7:0] OFS_PSW = 8'h1c;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h20;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h24;
   localparam logic [7:0] OFS_STATUS = 8'h28;
   // control fields
   localparam int CTRL_OP_LSB = 0;
   localparam int CTRL_OP_W = 3;
   localparam int CTRL_SWAP_BIT = 4;
   localparam int CTRL_ROUND_BIT = 5;
   localparam int CTRL_START_BIT = 8;
   // status word and interrupt fields
   localparam int PSW_STICKY_BIT = 27;
   localparam int IRQ_DONE_BIT = 0;
   localparam int IRQ_OVF_BIT = 1;
   localparam int IRQ_W = 2;
   localparam int STATUS_BUSY_BIT = 0;
   // reset values
   localparam logic [31:0] PSW_RESET = 32'h0000_0000;
   localparam logic [31:0] WORD_RESET = 32'h0000_0000;
   localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 2'h0;
   // rounding constant for top-word extraction
   localparam logic [63:0] ROUND_CONST = 64'h0000_0000_8000_0000;
   // operation codes
   localparam logic [2:0] OP_DUAL_MUL_SUB_ACC = 3'h0;
   localparam logic [2:0] OP_LONG_DUAL_MUL_SUB_ACC = 3'h1;
   localparam logic [2:0] OP_TOP_WORD_MUL_ACC = 3'h2;
   localparam logic [2:0] OP_TOP_WORD_MUL_SUB = 3'h3;
   localparam logic [2:0] OP_TOP_WORD_MULTIPLY = 3'h4;
   localparam logic [2:0] OP_DUAL_MUL_ADD = 3'h5;
   localparam logic [2:0] OP_DUAL_MUL_DIFF = 3'h6;
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_EXEC
   } smac_state_t;
endpackage : smac_pkg

// >>> src/smac_top.sv
// The address map and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module smac_top
   import smac_pkg::*;
(
   // clock and reset
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   // apb slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // interrupt and flag
   output logic irq_o,
   output logic sticky_ovf_o
);

   typedef struct packed {
      smac_state_t st;
      logic [CTRL_OP_W-1:0] op;
      logic swap;
      logic rnd;
      logic [31:0] first_factor;
      logic [31:0] second_factor;
      logic [31:0] addend_value;
      logic [31:0] pair_lower;
      logic [31:0] pair_upper;
      logic [31:0] result;
      logic [31:0] program_status_word;
      logic [IRQ_W-1:0] irq_stat;
      logic [IRQ_W-1:0] irq_mask;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic irq;
   } smac_regs_t;

   smac_regs_t r_q;
   smac_regs_t r_d;

   // datapath terms
   logic [15:0] sec_lo;
   logic [15:0] sec_hi;
   logic signed [31:0] prod_lo;
   logic signed [31:0] prod_hi;
   logic signed [31:0] prod_diff;
   logic [31:0] dual_sum;
   logic [31:0] acc_sum;
   logic [63:0] long_sum;
   logic signed [63:0] word_prod;
   logic [63:0] word_rnd;
   logic [31:0] top_word;
   logic [31:0] top_acc;
   logic [31:0] top_sub;
   logic [63:0] pair_val;
   logic acc_ovf;
   logic long_ovf;
   logic add_ovf;

   // bus helpers
   logic apb_done;
   logic wr_en;
   logic mapped;
   logic [31:0] rd_word;
   logic start_req;
   logic exec_ovf;
   logic exec_done;

   always_comb begin
      if (r_q.swap) begin
         sec_lo = r_q.second_factor[31:16];
         sec_hi = r_q.second_factor[15:0];
      end else begin
         sec_lo = r_q.second_factor[15:0];
         sec_hi = r_q.second_factor[31:16];
      end
   end

   smac_sgn_mul #(
      .W(16)
   ) u_smac_sgn_mul_lo (
      .fa_i(r_q.first_factor[15:0]),
      .fb_i(sec_lo),
      .prod_o(prod_lo)
   );
   smac_sgn_mul #(
      .W(16)
   ) u_smac_sgn_mul_hi (
      .fa_i(r_q.first_factor[31:16]),
      .fb_i(sec_hi),
      .prod_o(prod_hi)
   );

   assign prod_diff = prod_lo - prod_hi;
   assign pair_val = {r_q.pair_upper, r_q.pair_lower};

   // sums may leave their signed range: 32 bits for the dual and acc adders, 64 bits for the long one
   smac_ovf_add #(
      .W(32)
   ) u_smac_ovf_add_dual (
      .a_i(prod_lo),
      .b_i(prod_hi),
      .sum_o(dual_sum),
      .ovf_o(add_ovf)
   );
   smac_ovf_add #(
      .W(32)
   ) u_smac_ovf_add_acc (
      .a_i(prod_diff),
      .b_i(r_q.addend_value),
      .sum_o(acc_sum),
      .ovf_o(acc_ovf)
   );
   smac_ovf_add #(
      .W(64)
   ) u_smac_ovf_add_long (
      .a_i({{32{prod_diff[31]}}, prod_diff}),
      .b_i(pair_val),
      .sum_o(long_sum),
      .ovf_o(long_ovf)
   );

   smac_sgn_mul #(
      .W(32)
   ) u_smac_sgn_mul_word (
      .fa_i(r_q.first_factor),
      .fb_i(r_q.second_factor),
      .prod_o(word_prod)
   );

   always_comb begin
      word_rnd = r_q.rnd ? (word_prod + ROUND_CONST) : word_prod;
      top_word = word_rnd[63:32];
      top_acc = r_q.addend_value + top_word;
      top_sub = r_q.addend_value - top_word;
   end

   always_comb begin
      apb_done = psel_i & penable_i & r_q.pready;
      wr_en = apb_done & pwrite_i;
      start_req = wr_en & (paddr_i == OFS_CTRL) & pwdata_i[CTRL_START_BIT];
      mapped = 1'b1;
      case (paddr_i)
         OFS_CTRL: begin
            rd_word = 32'h0;
            rd_word[CTRL_OP_LSB +: CTRL_OP_W] = r_q.op;
            rd_word[CTRL_SWAP_BIT] = r_q.swap;
            rd_word[CTRL_ROUND_BIT] = r_q.rnd;
         end
         OFS_FIRST: rd_word = r_q.first_factor;
         OFS_SECOND: rd_word = r_q.second_factor;
         OFS_ADDEND: rd_word = r_q.addend_value;
         OFS_PAIR_LO: rd_word = r_q.pair_lower;
         OFS_PAIR_HI: rd_word = r_q.pair_upper;
         OFS_RESULT: rd_word = r_q.result;
         OFS_PSW: rd_word = r_q.program_status_word;
         OFS_IRQ_STAT: rd_word = {30'h0, r_q.irq_stat};
         OFS_IRQ_MASK: rd_word = {30'h0, r_q.irq_mask};
         OFS_STATUS: begin
            rd_word = 32'h0;
            rd_word[STATUS_BUSY_BIT] = (r_q.st == ST_EXEC);
         end
         default: begin
            rd_word = 32'h0;
            mapped = 1'b0;
         end
      endcase
   end

   always_comb begin
      r_d = r_q;
      exec_ovf = 1'b0;
      exec_done = 1'b0;

      // one wait state: pready rises in the second access cycle
      r_d.pready = psel_i & penable_i & ~r_q.pready;
      if (psel_i & penable_i & ~r_q.pready) begin
         r_d.prdata = pwrite_i ? 32'h0 : rd_word;
         r_d.pslverr = ~mapped;
      end else begin
         r_d.prdata = 32'h0;
         r_d.pslverr = 1'b0;
      end

      // software writes; operand writes while busy are accepted as is
      if (wr_en) begin
         case (paddr_i)
            OFS_CTRL: begin
               if (r_q.st == ST_IDLE) begin
                  r_d.op = pwdata_i[CTRL_OP_LSB +: CTRL_OP_W];
                  r_d.swap = pwdata_i[CTRL_SWAP_BIT];
                  r_d.rnd = pwdata_i[CTRL_ROUND_BIT];
               end
            end
            OFS_FIRST: r_d.first_factor = pwdata_i;
            OFS_SECOND: r_d.second_factor = pwdata_i;
            OFS_ADDEND: r_d.addend_value = pwdata_i;
            OFS_PAIR_LO: r_d.pair_lower = pwdata_i;
            OFS_PAIR_HI: r_d.pair_upper = pwdata_i;
            OFS_RESULT: r_d.result = pwdata_i;
            OFS_PSW: r_d.program_status_word = pwdata_i;
            OFS_IRQ_STAT: r_d.irq_stat = r_q.irq_stat & ~pwdata_i[IRQ_W-1:0];
            OFS_IRQ_MASK: r_d.irq_mask = pwdata_i[IRQ_W-1:0];
            default: begin
            end
         endcase
      end

      case (r_q.st)
         ST_IDLE: begin
            // a start while busy is ignored
            if (start_req) begin
               r_d.st = ST_EXEC;
            end
         end
         ST_EXEC: begin
            exec_done = 1'b1;
            r_d.st = ST_IDLE;
            case (r_q.op)
               OP_DUAL_MUL_SUB_ACC: begin
                  r_d.result = acc_sum[31:0];
                  exec_ovf = acc_ovf;
               end
               OP_LONG_DUAL_MUL_SUB_ACC: begin
                  r_d.pair_lower = long_sum[31:0];
                  r_d.pair_upper = long_sum[63:32];
                  exec_ovf = long_ovf;
               end
               OP_TOP_WORD_MUL_ACC: r_d.result = top_acc;
               OP_TOP_WORD_MUL_SUB: r_d.result = top_sub;
               OP_TOP_WORD_MULTIPLY: r_d.result = top_word;
               OP_DUAL_MUL_ADD: begin
                  r_d.result = dual_sum[31:0];
                  exec_ovf = add_ovf;
               end
               OP_DUAL_MUL_DIFF: r_d.result = prod_diff;
               default: begin
               end
            endcase
         end
         default: r_d.st = ST_IDLE;
      endcase

      // set wins over a same-cycle write
      if (exec_ovf) begin
         r_d.program_status_word[PSW_STICKY_BIT] = 1'b1;
      end
      // event set wins over write-one-to-clear
      if (exec_done) begin
         r_d.irq_stat[IRQ_DONE_BIT] = 1'b1;
      end
      if (exec_ovf) begin
         r_d.irq_stat[IRQ_OVF_BIT] = 1'b1;
      end
      r_d.irq = |(r_d.irq_stat & r_d.irq_mask);
   end

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         r_q.st <= ST_IDLE;
         r_q.op <= OP_DUAL_MUL_SUB_ACC;
         r_q.swap <= 1'b0;
         r_q.rnd <= 1'b0;
         r_q.first_factor <= WORD_RESET;
         r_q.second_factor <= WORD_RESET;
         r_q.addend_value <= WORD_RESET;
         r_q.pair_lower <= WORD_RESET;
         r_q.pair_upper <= WORD_RESET;
         r_q.result <= WORD_RESET;
         r_q.program_status_word <= PSW_RESET;
         r_q.irq_stat <= '0;
         r_q.irq_mask <= IRQ_MASK_RESET;
         r_q.prdata <= WORD_RESET;
         r_q.pready <= 1'b0;
         r_q.pslverr <= 1'b0;
         r_q.irq <= 1'b0;
      end else begin
         r_q <= r_d;
      end
   end

   assign prdata_o = r_q.prdata;
   assign pready_o = r_q.pready;
   assign pslverr_o = r_q.pslverr;
   assign irq_o = r_q.irq;
   assign sticky_ovf_o = r_q.program_status_word[PSW_STICKY_BIT];

endmodule : smac_top

module smac_sgn_mul
   import smac_pkg::*;
#(
   parameter int W = 16
) (
   // factors
   input wire logic [W-1:0] fa_i,
   input wire logic [W-1:0] fb_i,
   // full-width signed product
   output logic [2*W-1:0] prod_o
);
   logic [2*W-1:0] fa_ext;
   logic [2*W-1:0] fb_ext;

   // sign-extended first, so the full-width product never wraps
   assign fa_ext = {{W{fa_i[W-1]}}, fa_i};
   assign fb_ext = {{W{fb_i[W-1]}}, fb_i};
   assign prod_o = fa_ext * fb_ext;
endmodule : smac_sgn_mul

module smac_ovf_add
   import smac_pkg::*;
#(
   parameter int W = 32
) (
   // signed operands
   input wire logic [W-1:0] a_i,
   input wire logic [W-1:0] b_i,
   // wrapped sum and signed overflow
   output logic [W-1:0] sum_o,
   output logic ovf_o
);
   logic [W:0] ext_sum;

   // one guard bit: overflow when it disagrees with the sign bit
   assign ext_sum = {a_i[W-1], a_i} + {b_i[W-1], b_i};
   assign sum_o = ext_sum[W-1:0];
   assign ovf_o = ext_sum[W] ^ ext_sum[W-1];
endmodule : smac_ovf_add

// >>> tb/smac_cpu_mdl.sv
`timescale 1ns/1ps
module smac_cpu_mdl (
   // clock
   input wire logic core_clk_i,
   // apb requester
   output logic psel_o,
   output logic penable_o,
   output logic pwrite_o,
   output logic [7:0] paddr_o,
   output logic [31:0] pwdata_o,
   input wire logic [31:0] prdata_i,
   input wire logic pready_i,
   input wire logic pslverr_i
);
   initial begin
      psel_o = 1'b0;
      penable_o = 1'b0;
      pwrite_o = 1'b0;
      paddr_o = 8'h00;
      pwdata_o = 32'h0000_0000;
   end
   // entered just after a rising edge; returns one idle edge later
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
      psel_o <= 1'b1;
      penable_o <= 1'b0;
      pwrite_o <= wr;
      paddr_o <= a;
      pwdata_o <= wd;
      @(posedge core_clk_i);
      penable_o <= 1'b1;
      do @(posedge core_clk_i); while (pready_i !== 1'b1);
      rd = prdata_i;
      err = pslverr_i;
      psel_o <= 1'b0;
      penable_o <= 1'b0;
      // released data lines must not keep looking valid
      pwdata_o <= ~wd;
      @(posedge core_clk_i);
   endtask : xfer
endmodule : smac_cpu_mdl

// >>> tb/smac_top_chk.sv
`timescale 1ns/1ps
module smac_top_chk
   import smac_pkg::*;
(
   // clock and reset
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   // apb
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [31:0] prdata_o,
   input wire logic pready_o,
   input wire logic pslverr_o,
   // interrupt and flag
   input wire logic irq_o,
   input wire logic sticky_ovf_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (sys_rst_i);
   sequence s_setup_access;
      psel_i && !penable_i ##1 psel_i && penable_i;
   endsequence
   sequence s_wr_done;
      pready_o && pwrite_i;
   endsequence
   a_ready_wait: assert property (s_setup_access |-> !pready_o ##1 pready_o)
      else $error("ready not after one wait state");
   a_ready_pulse: assert property (pready_o |=> !pready_o)
      else $error("ready longer than one cycle");
   a_ready_access: assert property (pready_o |-> psel_i && penable_i)
      else $error("ready outside access phase");
   a_err_ready: assert property (pslverr_o |-> pready_o)
      else $error("error without ready");
   a_rdata_quiet: assert property (!pready_o |-> prdata_o == 32'h0)
      else $error("read data outside answer");
   a_irq_cause: assert property ($rose(irq_o) |-> $past(pready_o && pwrite_i)
      || $past(pready_o && pwrite_i, 2)) else $error("irq rose without cause");
   a_sticky_cause: assert property ($rose(sticky_ovf_o) |-> $past(pready_o && pwrite_i)
      || $past(pready_o && pwrite_i, 2)) else $error("sticky flag rose without cause");
   a_sticky_hold: assert property ($fell(sticky_ovf_o) |-> $past(pready_o && pwrite_i
      && paddr_i == OFS_PSW)) else $error("sticky flag cleared by hardware");
   a_wr_quiet: assert property (s_wr_done |-> prdata_o == 32'h0)
      else $error("read data on a write answer");
   a_irq_drop: assert property ($fell(irq_o) |-> $past(pready_o && pwrite_i))
      else $error("irq fell without a write");
endmodule : smac_top_chk

bind smac_top smac_top_chk u_smac_top_chk (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
   .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
   .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
   .irq_o(irq_o), .sticky_ovf_o(sticky_ovf_o));

// >>> tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   import smac_pkg::*;
   logic core_clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic psel, penable, pwrite, pready, pslverr, irq, sticky, err, stk_e, ov;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rdv, bb, hw;
   logic [7:0] ctl;
   logic signed [65:0] p0, p1, pr, s;
   int n_fail = 0;
   int comparisons = 0;
   int cycles = 0;
   localparam logic [63:0] ACC = 64'h0000_0001_ffff_fffe;
   logic [7:0] c_ctl [9] = '{8'h00, 8'h10, 8'h01, 8'h22, 8'h03, 8'h24, 8'h04, 8'h15, 8'h16};
   logic [31:0] c_a [9] = '{32'h8000_7fff, 32'h0002_0003, 32'h0003_0004, 32'h7fff_ffff,
      32'h8000_0000, 32'hffff_ffff, 32'hffff_ffff, 32'h8000_8000, 32'h0002_0003};
   logic [31:0] c_b [9] = '{32'h8000_8000, 32'h0005_0007, 32'h0001_0002, 32'h7fff_ffff,
      32'h7fff_ffff, 32'h0000_0001, 32'h0000_0001, 32'h8000_8000, 32'h0005_0007};
   logic [31:0] c_c [9] = '{32'h0, 32'h7fff_ffff, 32'h0, 32'h1, 32'ha, 32'h0, 32'h0, 32'h0, 32'h0};
   always #50 core_clk_i = ~core_clk_i;
   smac_top u_smac_top (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
      .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .irq_o(irq),
      .sticky_ovf_o(sticky));
   smac_cpu_mdl u_smac_cpu_mdl (.core_clk_i(core_clk_i), .psel_o(psel), .penable_o(penable),
      .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata), .prdata_i(prdata),
      .pready_i(pready), .pslverr_i(pslverr));
   task automatic give_verdict();
      if (n_fail == 0 && comparisons > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : give_verdict
   task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      u_smac_cpu_mdl.xfer(1'b1, a, d, rdv, err);
   endtask : wr
   task automatic rd(input logic [7:0] a);
      u_smac_cpu_mdl.xfer(1'b0, a, 32'h0, rdv, err);
   endtask : rd
   // a hung poll must still reach the verdict
   always @(posedge core_clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         n_fail++;
         give_verdict();
      end
   end
   initial begin
      stk_e = 1'b0;
      repeat (4) @(posedge core_clk_i);
      sys_rst_i <= 1'b0;
      rd(OFS_PSW);
      chk("psw_reset", rdv, PSW_RESET);
      for (int i = 0; i < 9; i++) begin
         ctl = c_ctl[i];
         bb = ctl[4] ? {c_b[i][15:0], c_b[i][31:16]} : c_b[i];
         p0 = $signed(c_a[i][15:0]) * $signed(bb[15:0]);
         p1 = $signed(c_a[i][31:16]) * $signed(bb[31:16]);
         pr = $signed(c_a[i]) * $signed(c_b[i]) + (ctl[5] ? 66'sh8000_0000 : 66'sh0);
         hw = pr[63:32];
         case (ctl[2:0])
            OP_DUAL_MUL_SUB_ACC: s = p0 - p1 + $signed(c_c[i]);
            OP_LONG_DUAL_MUL_SUB_ACC: s = p0 - p1 + $signed(ACC);
            OP_TOP_WORD_MUL_ACC: s = {34'h0, hw + c_c[i]};
            OP_TOP_WORD_MUL_SUB: s = {34'h0, c_c[i] - hw};
            OP_TOP_WORD_MULTIPLY: s = {34'h0, hw};
            OP_DUAL_MUL_ADD: s = p0 + p1;
            default: s = p0 - p1;
         endcase
         ov = 1'b0;
         if (ctl[2:0] == OP_LONG_DUAL_MUL_SUB_ACC) begin
            ov = s[64] != s[63];
         end else if (ctl[2:0] == OP_DUAL_MUL_SUB_ACC || ctl[2:0] == OP_DUAL_MUL_ADD) begin
            ov = s[33:31] != {3{s[31]}};
         end
         stk_e |= ov;
         wr(OFS_FIRST, c_a[i]);
         wr(OFS_SECOND, c_b[i]);
         wr(OFS_ADDEND, c_c[i]);
         wr(OFS_PAIR_LO, ACC[31:0]);
         wr(OFS_PAIR_HI, ACC[63:32]);
         wr(OFS_CTRL, {23'h0, 1'b1, ctl});
         do rd(OFS_STATUS); while (rdv[STATUS_BUSY_BIT] !== 1'b0);
         if (ctl[2:0] == OP_LONG_DUAL_MUL_SUB_ACC) begin
            rd(OFS_PAIR_LO);
            chk("pair_lower", rdv, s[31:0]);
            rd(OFS_PAIR_HI);
            chk("pair_upper", rdv, s[63:32]);
         end else begin
            rd(OFS_RESULT);
            chk("result", rdv, s[31:0]);
         end
         chk("sticky", sticky, stk_e);
         rd(OFS_IRQ_STAT);
         chk("irq_stat", rdv, {30'h0, ov, 1'b1});
         chk("irq_masked", irq, i > 0);
         wr(OFS_IRQ_MASK, 32'h3);
         chk("irq_raised", irq, 1'b1);
         wr(OFS_IRQ_STAT, 32'h3);
         chk("irq_cleared", irq, 1'b0);
      end
      rd(OFS_PSW);
      chk("psw_sticky", rdv[PSW_STICKY_BIT], 1'b1);
      wr(OFS_PSW, 32'h0);
      chk("sticky_sw_clear", sticky, 1'b0);
      rd(8'h3c);
      chk("unmapped_err", err, 1'b1);
      chk("unmapped_data", rdv, 32'h0);
      wr(8'h3c, 32'hffff_ffff);
      chk("unmapped_wr_err", err, 1'b1);
      wr(OFS_RESULT, 32'h1234_5678);
      rd(OFS_RESULT);
      chk("result_wr", rdv, 32'h1234_5678);
      // mid-run reset must bring the result register back to zero
      sys_rst_i <= 1'b1;
      repeat (2) @(posedge core_clk_i);
      sys_rst_i <= 1'b0;
      rd(OFS_RESULT);
      chk("result_reset", rdv, WORD_RESET);
      give_verdict();
   end
endmodule : tb_top
